// >>> core/rdbl_regs.sv
// Reset delay timer and buck limit register bank on classic Wishbone
//
// Behaviour
// (R01) Trigger field selects delay timer start event
// (R02) Software avoids trigger 11 with pin mode
// (R03) Codes to 100000 give code times step
// (R04) Higher codes grow by 32.768 ms steps
// (R05) High bucks limit 1500 mA plus 100/code
// (R06) Memory buck limits doubled when merged
// (R07) Core and auxiliary limit 500 mA base
// (R08) Full-current mode doubles core, auxiliary limits
// (R09) Mode 00 follows voltage register sleep choice
// (R10) Modes 01/10/11 force sleep, sync, auto
// (R11) Pull-down when disabled unless bit, dual-phase
// (R12) Sense select bits form a mask
// (R13) Software never writes sense select 000
// (R14) Fields read back; reserved bits read zero
`timescale 1ns/1ns
module rdbl_regs
  import rdbl_pkg::*;
#(
  parameter int UNIT_CYCLES = LP_UNIT_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [9:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        external_wake_event_in,
  input  wire logic        system_domain_up_in,
  input  wire logic        power_domain_up_in,
  input  wire logic        reset_state_exit_in,
  output logic             delay_done_out,
  input  wire logic        memory_merged_in,
  input  wire logic        first_core_full_in,
  input  wire logic        second_core_full_in,
  input  wire logic        auxiliary_full_in,
  output logic      [12:0] memory_buck_limit_out,
  output logic      [12:0] io_buck_limit_out,
  output logic      [12:0] peripheral_buck_limit_out,
  output logic      [12:0] auxiliary_buck_limit_out,
  output logic      [12:0] first_core_buck_limit_out,
  output logic      [12:0] second_core_buck_limit_out,
  input  wire logic        voltage_reg_sleep_in,
  input  wire logic        second_core_disabled_in,
  input  wire logic        dual_phase_in,
  output logic             second_core_sleep_out,
  output logic             second_core_sync_out,
  output logic             second_core_auto_out,
  output logic             second_core_pulldown_out,
  output logic             second_core_output_sense_out,
  output logic             core_switch_sense_out,
  output logic             peripheral_switch_sense_out
);

  localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

  // Delay length code to count of 1.024 ms units
  function automatic logic [10:0] delay_units(
    input logic [5:0] code
  );
    logic [10:0] u;
    u = 11'(code);
    if (code > LP_LIN_MAX) begin // R04
      u = 11'(code - LP_LONG_BASE) << LP_LONG_SHIFT;
    end
    return u; // R03
  endfunction : delay_units

  // Limit code to milliamps, optionally doubled
  function automatic logic [12:0] limit_ma(
    input logic [12:0] base,
    input logic [3:0]  code,
    input logic        dbl
  );
    logic [12:0] v;
    v = base + 13'(code) * LP_STEP_MA;
    if (dbl) begin
      v = v << 1;
    end
    return v;
  endfunction : limit_ma

  rdbl_state_s q;
  rdbl_state_s next_q;

  logic [7:0] idx;
  logic       req;
  logic       wr;
  logic       trig;
  logic [1:0] evt;
  logic [5:0] tcode;
  logic [1:0] mode;
  logic [7:0] stat;
  logic [10:0] tunits;

  assign idx   = wb_adr_in[9:2];
  assign req   = wb_cyc_in && wb_stb_in;
  assign wr    = req && wb_we_in && q.ack && wb_sel_in[0];
  assign evt   = q.rst_cfg[LP_EVT_POS +: 2];
  assign tcode = q.rst_cfg[LP_TMR_POS +: 6];
  assign mode  = q.c2_cfg[LP_MODE_POS +: 2];
  assign tunits = delay_units(tcode);

  // Trigger event select
  always_comb begin
    unique case (evt)
      LP_EVT_WAKE: trig = external_wake_event_in; // R01
      LP_EVT_SYS:  trig = system_domain_up_in; // R01
      LP_EVT_PWR:  trig = power_domain_up_in; // R01
      LP_EVT_RSTX: trig = reset_state_exit_in; // R01
    endcase
  end

  // Status word
  always_comb begin
    stat = 8'h00;
    stat[LP_RUN_POS] = (q.st == ST_COUNT);
    stat[LP_EXP_POS] = (q.st == ST_DONE);
  end

  always_comb begin
    next_q = q;
    // Bus slave: answer one cycle after the request
    next_q.ack  = req && !q.ack;
    next_q.rdat = 8'h00;
    if (req && !q.ack && !wb_we_in) begin
      unique case (idx)
        LP_IDX_RST:   next_q.rdat = q.rst_cfg; // R14
        LP_IDX_LIM_A: next_q.rdat = q.lim_a;
        LP_IDX_LIM_B: next_q.rdat = q.lim_b;
        LP_IDX_LIM_C: next_q.rdat = q.lim_c;
        LP_IDX_C2:    next_q.rdat = q.c2_cfg; // R14
        LP_IDX_STAT:  next_q.rdat = stat;
        default:      next_q.rdat = 8'h00;
      endcase
    end
    // Writes take effect at the acknowledge edge
    if (wr) begin
      unique case (idx)
        LP_IDX_RST:   next_q.rst_cfg = wb_dat_in[7:0];
        LP_IDX_LIM_A: next_q.lim_a   = wb_dat_in[7:0];
        LP_IDX_LIM_B: next_q.lim_b   = wb_dat_in[7:0];
        LP_IDX_LIM_C: next_q.lim_c   = wb_dat_in[7:0];
        LP_IDX_C2:
          next_q.c2_cfg = wb_dat_in[7:0] & LP_C2_MASK; // R14
        default: next_q.rst_cfg = q.rst_cfg;
      endcase
    end
    // Reset delay timer
    unique case (q.st)
      ST_IDLE, ST_DONE: begin
        next_q.presc = 16'h0000;
      end
      ST_COUNT: begin
        if (q.presc == UNIT_LAST) begin
          next_q.presc = 16'h0000;
          next_q.units = q.units - 11'h001;
          if (q.units == 11'h001) begin
            next_q.st = ST_DONE;
          end
        end else begin
          next_q.presc = q.presc + 16'h0001;
        end
      end
    endcase
    if (trig) begin // R01
      next_q.presc = 16'h0000;
      next_q.units = tunits; // R03 R04
      if (tunits == 11'h000) begin
        next_q.st = ST_DONE; // R03
      end else begin
        next_q.st = ST_COUNT;
      end
    end
    // Current limits
    next_q.lim_mem  = limit_ma(LP_HI_BASE_MA,
      q.lim_a[LP_HI_POS +: 4], memory_merged_in); // R05 R06
    next_q.lim_io   = limit_ma(LP_HI_BASE_MA,
      q.lim_a[LP_LO_POS +: 4], 1'b0); // R05
    next_q.lim_peri = limit_ma(LP_HI_BASE_MA,
      q.lim_b[LP_HI_POS +: 4], 1'b0); // R05
    next_q.lim_aux  = limit_ma(LP_LO_BASE_MA,
      q.lim_b[LP_LO_POS +: 4], auxiliary_full_in); // R07 R08
    next_q.lim_c2   = limit_ma(LP_LO_BASE_MA,
      q.lim_c[LP_HI_POS +: 4], second_core_full_in); // R07 R08
    next_q.lim_c1   = limit_ma(LP_LO_BASE_MA,
      q.lim_c[LP_LO_POS +: 4], first_core_full_in); // R07 R08
    // Second core buck operating mode
    unique case (mode)
      LP_MODE_VREG: begin
        next_q.sleep  = voltage_reg_sleep_in; // R09
        next_q.sync   = !voltage_reg_sleep_in; // R09
        next_q.auto_m = 1'b0;
      end
      LP_MODE_SLEEP: begin
        next_q.sleep  = 1'b1; // R10
        next_q.sync   = 1'b0;
        next_q.auto_m = 1'b0;
      end
      LP_MODE_SYNC: begin
        next_q.sleep  = 1'b0;
        next_q.sync   = 1'b1; // R10
        next_q.auto_m = 1'b0;
      end
      LP_MODE_AUTO: begin
        next_q.sleep  = 1'b0;
        next_q.sync   = 1'b0;
        next_q.auto_m = 1'b1; // R10
      end
    endcase
    next_q.pd = second_core_disabled_in
      && !q.c2_cfg[LP_PD_POS] && !dual_phase_in; // R11
    next_q.fb = q.c2_cfg[LP_FB_POS +: 3]; // R12
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q         <= '0;
      q.rst_cfg <= LP_RST_RV;
      q.lim_a   <= LP_LIM_RV;
      q.lim_b   <= LP_LIM_RV;
      q.lim_c   <= LP_LIM_RV;
      q.c2_cfg  <= LP_C2_RV;
      q.st      <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign wb_ack_out = q.ack;
  assign wb_dat_out = {24'h000000, q.rdat};
  assign delay_done_out = (q.st == ST_DONE);
  assign memory_buck_limit_out      = q.lim_mem;
  assign io_buck_limit_out          = q.lim_io;
  assign peripheral_buck_limit_out  = q.lim_peri;
  assign auxiliary_buck_limit_out   = q.lim_aux;
  assign first_core_buck_limit_out  = q.lim_c1;
  assign second_core_buck_limit_out = q.lim_c2;
  assign second_core_sleep_out    = q.sleep;
  assign second_core_sync_out     = q.sync;
  assign second_core_auto_out     = q.auto_m;
  assign second_core_pulldown_out = q.pd;
  assign second_core_output_sense_out = q.fb[0];
  assign core_switch_sense_out        = q.fb[1];
  assign peripheral_switch_sense_out  = q.fb[2];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_start;
    trig && tunits != 11'h000;
  endsequence

  sequence s_last_tick;
    q.st == ST_COUNT && q.units == 11'h001
      && q.presc == UNIT_LAST && !trig;
  endsequence

  AST_ACK_PULSE: assert property ( // R14
    wb_ack_out |=> !wb_ack_out
  ) else $error("ack held longer than one cycle");

  AST_C2_RSVD: assert property ( // R14
    wr && idx == LP_IDX_C2 |=>
      q.c2_cfg == ($past(wb_dat_in[7:0]) & LP_C2_MASK)
  ) else $error("second core config write wrong");

  AST_START: assert property ( // R01
    s_start |=> q.st == ST_COUNT
      && q.units == $past(tunits)
  ) else $error("delay timer did not start");

  AST_ZERO: assert property ( // R03
    trig && tcode == 6'h00 |=> delay_done_out
  ) else $error("zero delay did not finish at once");

  AST_EXPIRE: assert property ( // R03
    s_last_tick |=> delay_done_out ##1 delay_done_out || $past(trig)
  ) else $error("delay timer did not expire");

  AST_LONG: assert property ( // R04
    trig && tcode == 6'h3f |=> q.units == LP_UNITS_MAX
  ) else $error("longest delay code wrong");

  AST_MEM_LIM: assert property ( // R05
    !rst_in && !memory_merged_in |=>
      memory_buck_limit_out == LP_HI_BASE_MA
      + 13'($past(q.lim_a[7:4])) * LP_STEP_MA
  ) else $error("memory buck limit wrong");

  AST_CORE_DBL: assert property ( // R08
    ##1 $past(first_core_full_in) |->
      first_core_buck_limit_out == 13'((LP_LO_BASE_MA
      + 13'($past(q.lim_c[3:0])) * LP_STEP_MA) << 1)
  ) else $error("core buck limit not doubled");

  AST_MODE: assert property ( // R10
    mode == LP_MODE_SLEEP |=>
      second_core_sleep_out && !second_core_sync_out
  ) else $error("forced sleep mode not applied");

  AST_PD: assert property ( // R11
    dual_phase_in |=> !second_core_pulldown_out
  ) else $error("pull-down on in dual-phase mode");

  AST_FB: assert property ( // R12
    ##1 1'b1 |-> peripheral_switch_sense_out
      == $past(q.c2_cfg[2])
  ) else $error("sense mask not followed");

  AST_MEM_DBL: assert property ( // R06
    !rst_in && memory_merged_in |=>
      memory_buck_limit_out == 13'((LP_HI_BASE_MA
      + 13'($past(q.lim_a[7:4])) * LP_STEP_MA) << 1)
  ) else $error("merged memory buck limit not doubled");

  AST_AUX_LIM: assert property ( // R07
    !rst_in && !auxiliary_full_in |=>
      auxiliary_buck_limit_out == LP_LO_BASE_MA
      + 13'($past(q.lim_b[3:0])) * LP_STEP_MA
  ) else $error("auxiliary buck limit wrong");

  AST_VREG: assert property ( // R09
    !rst_in && mode == LP_MODE_VREG |=>
      second_core_sleep_out == $past(voltage_reg_sleep_in)
      && second_core_sync_out == !$past(voltage_reg_sleep_in)
  ) else $error("mode 00 does not follow voltage registers");

  AST_AUTO: assert property ( // R10
    mode == LP_MODE_AUTO |=> second_core_auto_out
      && !second_core_sleep_out && !second_core_sync_out
  ) else $error("automatic mode not applied");

  AST_PD_ON: assert property ( // R11
    !rst_in && second_core_disabled_in && !q.c2_cfg[LP_PD_POS]
      && !dual_phase_in |=> second_core_pulldown_out
  ) else $error("pull-down missing while disabled");

  AST_SENSE: assert property ( // R12
    !rst_in |=> {peripheral_switch_sense_out, core_switch_sense_out,
      second_core_output_sense_out} == $past(q.c2_cfg[2:0])
  ) else $error("sense mask bits not followed");

endmodule : rdbl_regs

// >>> core/rdbl_pkg.sv
// Constants and types for the reset delay and buck limit register bank
package rdbl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] LP_IDX_RST   = 8'h99;
  localparam logic [7:0] LP_IDX_LIM_A = 8'h9a;
  localparam logic [7:0] LP_IDX_LIM_B = 8'h9b;
  localparam logic [7:0] LP_IDX_LIM_C = 8'h9c;
  localparam logic [7:0] LP_IDX_C2    = 8'h9d;
  localparam logic [7:0] LP_IDX_STAT  = 8'hf0;
  // Reset values
  localparam logic [7:0] LP_RST_RV    = 8'h00;
  localparam logic [7:0] LP_LIM_RV    = 8'h00;
  localparam logic [7:0] LP_C2_RV     = 8'h01;
  // Field positions
  localparam int LP_EVT_POS  = 6;
  localparam int LP_TMR_POS  = 0;
  localparam int LP_HI_POS   = 4;
  localparam int LP_LO_POS   = 0;
  localparam int LP_MODE_POS = 6;
  localparam int LP_PD_POS   = 5;
  localparam int LP_FB_POS   = 0;
  localparam int LP_RUN_POS  = 0;
  localparam int LP_EXP_POS  = 1;
  localparam logic [7:0] LP_C2_MASK = 8'he7;
  // Trigger codes
  localparam logic [1:0] LP_EVT_WAKE = 2'h0;
  localparam logic [1:0] LP_EVT_SYS  = 2'h1;
  localparam logic [1:0] LP_EVT_PWR  = 2'h2;
  localparam logic [1:0] LP_EVT_RSTX = 2'h3;
  // Operating mode codes
  localparam logic [1:0] LP_MODE_VREG  = 2'h0;
  localparam logic [1:0] LP_MODE_SLEEP = 2'h1;
  localparam logic [1:0] LP_MODE_SYNC  = 2'h2;
  localparam logic [1:0] LP_MODE_AUTO  = 2'h3;
  // Delay length coding
  localparam logic [5:0]  LP_LIN_MAX    = 6'h20;
  localparam logic [5:0]  LP_LONG_BASE  = 6'h1f;
  localparam int          LP_LONG_SHIFT = 5;
  localparam logic [10:0] LP_UNITS_MAX  = 11'h400;
  // Timing: one delay step is 1.024 ms
  localparam int LP_STEP_US  = 1024;
  localparam int LP_CLK_MHZ  = 20;
  localparam int LP_UNIT_CYC = LP_STEP_US * LP_CLK_MHZ;
  // Current limit coding in mA
  localparam logic [12:0] LP_HI_BASE_MA = 13'h5dc;
  localparam logic [12:0] LP_LO_BASE_MA = 13'h1f4;
  localparam logic [12:0] LP_STEP_MA    = 13'h064;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_COUNT = 3'h2,
    ST_DONE  = 3'h4
  } rdbl_state_e;

  typedef struct packed {
    logic [7:0]  rst_cfg;
    logic [7:0]  lim_a;
    logic [7:0]  lim_b;
    logic [7:0]  lim_c;
    logic [7:0]  c2_cfg;
    rdbl_state_e st;
    logic [15:0] presc;
    logic [10:0] units;
    logic        ack;
    logic [7:0]  rdat;
    logic [12:0] lim_mem;
    logic [12:0] lim_io;
    logic [12:0] lim_peri;
    logic [12:0] lim_aux;
    logic [12:0] lim_c1;
    logic [12:0] lim_c2;
    logic        sleep;
    logic        sync;
    logic        auto_m;
    logic        pd;
    logic [2:0]  fb;
  } rdbl_state_s;
endpackage : rdbl_pkg

// >>> sim/test_rdbl_regs.sv
// Self-checking bench for the reset delay and buck limit register bank
`timescale 1ns/1ns
module test_rdbl_regs;
  import rdbl_pkg::*;
  localparam int UC = 4;
  logic        ref_clk_in;
  logic        rst_in;
  logic        cyc, stb, we, ack, done, vslp, dis, dual;
  logic        slp, syn, aut, pd;
  logic [9:0]  adr;
  logic [3:0]  sel, evt, full;
  logic [31:0] wdat, rdat, q;
  logic [12:0] lim [6];
  logic [2:0]  fb;
  logic [7:0]  g [3];
  logic [7:0]  d;
  int          seed = 9;
  int          err_count = 0;
  int          n_compared = 0;

  rdbl_regs #(.UNIT_CYCLES(UC)) i_rdbl_regs (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .external_wake_event_in(evt[0]), .system_domain_up_in(evt[1]),
    .power_domain_up_in(evt[2]), .reset_state_exit_in(evt[3]),
    .delay_done_out(done), .memory_merged_in(full[0]),
    .first_core_full_in(full[1]), .second_core_full_in(full[2]),
    .auxiliary_full_in(full[3]), .memory_buck_limit_out(lim[0]),
    .io_buck_limit_out(lim[1]), .peripheral_buck_limit_out(lim[2]),
    .auxiliary_buck_limit_out(lim[3]), .first_core_buck_limit_out(lim[4]),
    .second_core_buck_limit_out(lim[5]), .voltage_reg_sleep_in(vslp),
    .second_core_disabled_in(dis), .dual_phase_in(dual),
    .second_core_sleep_out(slp), .second_core_sync_out(syn),
    .second_core_auto_out(aut), .second_core_pulldown_out(pd),
    .second_core_output_sense_out(fb[0]), .core_switch_sense_out(fb[1]),
    .peripheral_switch_sense_out(fb[2]));

  task automatic tally_and_finish;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single Wishbone cycle; waits for ack with a bound
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] dv, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, dv};
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      chk(ack, 1);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  function automatic logic [12:0] lim_exp(input logic hi,
                                          input logic [3:0] c,
                                          input logic dbl);
    logic [12:0] v;
    v = (hi ? 13'd1500 : 13'd500) + 13'd100 * c;
    return dbl ? v << 1 : v;
  endfunction : lim_exp

  // Starts the delay from the selected event and times its expiry
  task automatic timer(input logic [1:0] e, input logic [5:0] c);
    int u;
    u = (c <= 32) ? c : (c - 31) * 32;
    wb(1, 8'h99, {e, c}, q);
    @(posedge ref_clk_in);
    evt[e] <= 1'b1;
    @(posedge ref_clk_in);
    evt <= 4'h0;
    if (u > 0) begin
      repeat (u * UC - 1) @(posedge ref_clk_in);
      #1 chk(done, 0);
    end
    @(posedge ref_clk_in);
    #1 chk(done, 1);
    @(posedge ref_clk_in);
    evt[e + 2'h1] <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    evt <= 4'h0;
    #1 chk(done, 1);
  endtask : timer

  initial begin
    ref_clk_in = 0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    err_count++;
    tally_and_finish();
  end

  initial begin
    rst_in = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hf;
    wdat = 0; evt = 0; full = 0; vslp = 0; dis = 0; dual = 0;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int i = 8'h99; i <= 8'h9d; i++) begin
      wb(0, i[7:0], 8'h00, q);
      chk(q, (i == 8'h9d) ? 1 : 0);
    end
    wb(1, 8'h98, 8'h5a, q);
    wb(0, 8'h98, 8'h00, q);
    chk(q, 0);
    for (int i = 0; i < 12; i++) begin
      full <= 4'($random(seed));
      for (int k = 0; k < 3; k++) begin
        g[k][7:4] = (i < 2) ? 4'h9 * i : $unsigned($random(seed)) % 10;
        g[k][3:0] = (i < 2) ? 4'h9 * i : $unsigned($random(seed)) % 10;
        wb(1, 8'(8'h9a + k), g[k], q);
        wb(0, 8'(8'h9a + k), 8'h00, q);
        chk(q, g[k]);
      end
      repeat (2) @(posedge ref_clk_in);
      chk(lim[0], lim_exp(1, g[0][7:4], full[0]));
      chk(lim[1], lim_exp(1, g[0][3:0], 0));
      chk(lim[2], lim_exp(1, g[1][7:4], 0));
      chk(lim[3], lim_exp(0, g[1][3:0], full[3]));
      chk(lim[4], lim_exp(0, g[2][3:0], full[1]));
      chk(lim[5], lim_exp(0, g[2][7:4], full[2]));
    end
    for (int j = 0; j < 16; j++) begin
      {vslp, dis, dual} <= 3'($random(seed));
      // Sense mask kept nonzero, as software must
      d = {j[1:0], j[2], 2'b11, 3'(j % 7 + 1)};
      wb(1, 8'h9d, d, q);
      wb(0, 8'h9d, 8'h00, q);
      chk(q, d & 8'he7);
      repeat (2) @(posedge ref_clk_in);
      chk(slp, j[1:0] == 1 || (j[1:0] == 0 && vslp));
      chk(syn, j[1:0] == 2 || (j[1:0] == 0 && !vslp));
      chk(aut, j[1:0] == 3);
      chk(pd, dis && !d[5] && !dual);
      chk(fb, d[2:0]);
    end
    sel <= 4'he;
    wb(1, 8'h99, 8'hff, q);
    sel <= 4'hf;
    wb(0, 8'h99, 8'h00, q);
    chk(q, 0);
    timer(0, 6'd0);
    timer(1, 6'd1);
    timer(2, 6'd32);
    timer(3, 6'd33);
    timer(0, 6'd63);
    wb(0, 8'hf0, 8'h00, q);
    chk(q, 32'h2);
    evt[0] <= 1'b1;
    @(posedge ref_clk_in);
    evt <= 4'h0;
    wb(0, 8'hf0, 8'h00, q);
    chk(q, 32'h1);
    chk(done, 0);
    tally_and_finish();
  end
endmodule : test_rdbl_regs
